// ===== logic/pecp_engine_port.sv
// Engine side of the print engine to controller port, with its register port.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module pecp_engine_port
    import pecp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rear_cover_open,
    input wire logic front_cover_open,
    input wire logic fan_alarm,
    input wire logic exit_sensor_n,
    input wire logic prefeed_req_n,
    input wire logic start_req_n,
    input wire logic ctrl_power_ready_n,
    input wire logic command_busy_n,
    input wire logic command_n,
    input wire logic link_clock_n_i,
    output logic link_clock_n_o,
    output logic link_clock_n_oe_n,
    output logic engine_status_n,
    output logic status_busy_n,
    output logic ready_n,
    output logic engine_power_ready_n,
    output logic page_sync_n,
    output logic line_sync_n,
    output logic sleep_ctrl_n,
    output logic heater_on_n,
    output logic exit_step_phase_a,
    output logic exit_step_phase_b,
    output logic exit_step_phase_a_n,
    output logic exit_step_phase_b_n,
    output logic exit_current_sel_a,
    output logic exit_current_sel_b
);

    localparam pecp_state_t ST_RST = '{
        s1: PINS_IDLE, s2: PINS_IDLE, prev: PINS_IDLE, ctrl: CTRL_RST,
        line_period: LINE_PERIOD_RST, lines_page: LINES_PAGE_RST,
        step_div: STEP_DIV_RST, tx: TX_IDLE,
        sta_n: 1'b1, status_busy_n_n: 1'b1, lclk_o: 1'b1, lclk_oe_n: 1'b1, rdy_n: 1'b1,
        engine_power_ready_n_n: 1'b1, page_n: 1'b1, line_n: 1'b1, sleep_n: 1'b1, heat_n: 1'b1,
        default: '0
    };

    pecp_state_t st_q;
    pecp_state_t st_d;
    pecp_pins_t pins;
    pecp_status_t stat;
    logic engine_ok;
    logic [1:0] step_phase;
    logic rx_edge;
    logic link_ok;

    // Gives a falling edge of a synchronised active-low request.
    function automatic logic fell_edge(input logic prev_lvl, input logic now_lvl);
        fell_edge = prev_lvl & ~now_lvl;
    endfunction : fell_edge

    // Gray sequence for the two-phase full-step drive.
    function automatic logic [1:0] step_code(input logic [1:0] idx);
        step_code = idx ^ {1'b0, idx[1]};
    endfunction : step_code

    always_comb
    begin
        pins = '{rear_open: rear_cover_open, front_open: front_cover_open,
                 fan_alarm: fan_alarm, exit_n: exit_sensor_n, prefeed_n: prefeed_req_n,
                 start_n: start_req_n, ctrl_power_ready_n_n: ctrl_power_ready_n,
                 command_busy_n_n: command_busy_n, cmd_n: command_n, lclk_n: link_clock_n_i};
        st_d = st_q;
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
        st_d.ctrl.print_done = 1'b0;

        stat = '{tx_abort: st_q.tx_abort, print_active: st_q.print_active,
                 tx_busy: st_q.tx != TX_IDLE, cmd_valid: st_q.cmd_valid,
                 start_seen: st_q.start_seen, prefeed_seen: st_q.prefeed_seen,
                 cmd_busy: ~st_q.s2.command_busy_n_n, ctrl_ready: ~st_q.s2.ctrl_power_ready_n_n,
                 paper_at_exit: st_q.s2.exit_n,
                 fan_fault: st_q.s2.fan_alarm,
                 front_open: st_q.s2.front_open,
                 rear_open: st_q.s2.rear_open};

        // Software writes; a write-one clear loses against a same-cycle set below.
        if (reg_wr)
        begin
            unique case (reg_addr)
                REG_CTRL: st_d.ctrl = reg_wdata[$bits(pecp_ctrl_t)-1:0];
                REG_STATUS:
                begin
                    if (reg_wdata[ST_PREFEED]) st_d.prefeed_seen = 1'b0;
                    if (reg_wdata[ST_START]) st_d.start_seen = 1'b0;
                    if (reg_wdata[ST_CMD_VALID]) st_d.cmd_valid = 1'b0;
                    if (reg_wdata[ST_TX_ABORT]) st_d.tx_abort = 1'b0;
                end
                REG_STAT_TX:
                begin
                    if (!st_q.tx_pend)
                    begin
                        st_d.tx_word = reg_wdata[7:0];
                        st_d.tx_pend = 1'b1;
                    end
                end
                REG_LINE_PERIOD: st_d.line_period = reg_wdata[15:0];
                REG_LINES_PAGE: st_d.lines_page = reg_wdata[15:0];
                REG_STEP_DIV: st_d.step_div = reg_wdata[15:0];
                default: ;
            endcase
        end
        if (st_d.ctrl.print_done)
            st_d.print_active = 1'b0;

        st_d.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL: st_d.rdata = 32'({1'b0, st_q.ctrl[$bits(pecp_ctrl_t)-2:0]});
                REG_STATUS: st_d.rdata = 32'(stat);
                REG_STAT_TX: st_d.rdata = 32'(st_q.tx_word);
                REG_CMD_RX: st_d.rdata = 32'(st_q.rx_word);
                REG_LINE_PERIOD: st_d.rdata = 32'(st_q.line_period);
                REG_LINES_PAGE: st_d.rdata = 32'(st_q.lines_page);
                REG_STEP_DIV: st_d.rdata = 32'(st_q.step_div);
                default: st_d.rdata = '0;
            endcase
        end

        // Any interlock, fan alarm or software fault pulls power ready high.
        engine_ok = st_q.ctrl.init_done & ~st_q.ctrl.fault & ~st_q.s2.rear_open
                    & ~st_q.s2.front_open & ~st_q.s2.fan_alarm;
        st_d.engine_power_ready_n_n = ~engine_ok;
        st_d.rdy_n = ~(engine_ok & st_q.ctrl.standby & ~st_q.ctrl.power_save
                       & ~st_d.print_active);
        st_d.sleep_n = ~st_q.ctrl.power_save;
        st_d.heat_n = ~(st_q.ctrl.heater_on & ~st_q.s2.rear_open
                        & ~st_q.s2.front_open);

        if (fell_edge(st_q.prev.start_n, st_q.s2.start_n) && !st_q.rdy_n)
        begin
            st_d.print_active = 1'b1;
            st_d.start_seen = 1'b1;
            st_d.rdy_n = 1'b1;
        end
        if (fell_edge(st_q.prev.prefeed_n, st_q.s2.prefeed_n) && !st_q.rdy_n)
            st_d.prefeed_seen = 1'b1;

        // Command receive: sample on the rising edge of the controller's clock.
        rx_edge = ~st_q.prev.lclk_n & st_q.s2.lclk_n;
        if (st_q.s2.command_busy_n_n || st_q.tx != TX_IDLE)
            st_d.rx_bit = '0;
        else if (rx_edge)
        begin
            st_d.rx_sh = {st_q.rx_sh[6:0], ~st_q.s2.cmd_n};
            st_d.rx_bit = st_q.rx_bit + 3'h1;
            if (st_q.rx_bit == WORD_LAST_BIT)
            begin
                st_d.rx_word = {st_q.rx_sh[6:0], ~st_q.s2.cmd_n};
                st_d.cmd_valid = 1'b1;
            end
        end

        // Status transmit: busy low, then eight clocked bits, then release.
        link_ok = st_q.s2.command_busy_n_n & ~st_q.s2.ctrl_power_ready_n_n;
        if (st_q.tx_cnt != '0)
            st_d.tx_cnt = st_q.tx_cnt - 8'h01;
        if (st_q.tx != TX_IDLE && !link_ok)
        begin
            st_d.tx = TX_IDLE;
            st_d.status_busy_n_n = 1'b1;
            st_d.lclk_oe_n = 1'b1;
            st_d.lclk_o = 1'b1;
            st_d.sta_n = 1'b1;
            st_d.tx_pend = 1'b0;
            st_d.tx_abort = 1'b1;
        end
        else
        begin
            unique case (st_q.tx)
                TX_IDLE:
                begin
                    if (st_q.tx_pend && link_ok && !st_q.rx_bit[0] && st_q.rx_bit == '0)
                    begin
                        st_d.tx = TX_LEAD;
                        st_d.status_busy_n_n = 1'b0;
                        st_d.tx_sh = st_q.tx_word;
                        st_d.tx_bit = '0;
                        st_d.tx_cnt = LINK_HALF_CNT;
                    end
                end
                TX_LEAD, TX_HIGH:
                begin
                    if (st_q.tx_cnt == '0)
                    begin
                        if (st_q.tx == TX_HIGH && st_q.tx_bit == WORD_LAST_BIT)
                        begin
                            st_d.tx = TX_TAIL;
                            st_d.lclk_oe_n = 1'b1;
                            st_d.sta_n = 1'b1;
                        end
                        else
                        begin
                            st_d.tx = TX_LOW;
                            st_d.lclk_oe_n = 1'b0;
                            st_d.lclk_o = 1'b0;
                            st_d.sta_n = ~((st_q.tx == TX_HIGH) ? st_q.tx_sh[6]
                                           : st_q.tx_sh[7]);
                            if (st_q.tx == TX_HIGH)
                            begin
                                st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
                                st_d.tx_bit = st_q.tx_bit + 3'h1;
                            end
                        end
                        st_d.tx_cnt = LINK_HALF_CNT;
                    end
                end
                TX_LOW:
                begin
                    if (st_q.tx_cnt == '0)
                    begin
                        st_d.tx = TX_HIGH;
                        st_d.lclk_o = 1'b1;
                        st_d.tx_cnt = LINK_HALF_CNT;
                    end
                end
                TX_TAIL:
                begin
                    if (st_q.tx_cnt == '0)
                    begin
                        st_d.tx = TX_IDLE;
                        st_d.status_busy_n_n = 1'b1;
                        st_d.tx_pend = 1'b0;
                    end
                end
            endcase
        end

        // Line and page sync pacing while the scanner motor turns.
        st_d.line_n = 1'b1;
        st_d.page_n = 1'b1;
        if (!st_q.ctrl.scanner_run)
        begin
            st_d.line_cnt = '0;
            st_d.page_cnt = '0;
        end
        else if (st_q.line_cnt >= st_q.line_period - 16'h0001)
        begin
            st_d.line_cnt = '0;
            st_d.line_n = 1'b0;
            if (st_q.page_cnt == '0)
                st_d.page_n = 1'b0;
            st_d.page_cnt = (st_q.page_cnt >= st_q.lines_page - 16'h0001) ? '0
                            : st_q.page_cnt + 16'h0001;
        end
        else
            st_d.line_cnt = st_q.line_cnt + 16'h0001;

        // Exit stepper: one step per divider period, direction from control.
        if (!st_q.ctrl.exit_run)
            st_d.step_cnt = st_q.step_div;
        else if (st_q.step_cnt == '0)
        begin
            st_d.step_cnt = st_q.step_div;
            st_d.step_idx = st_q.ctrl.exit_dir ? st_q.step_idx - 2'h1
                            : st_q.step_idx + 2'h1;
        end
        else
            st_d.step_cnt = st_q.step_cnt - 16'h0001;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st_q <= ST_RST;
        else
            st_q <= st_d;
    end

    assign reg_rdata = st_q.rdata;
    assign link_clock_n_o = st_q.lclk_o;
    assign link_clock_n_oe_n = st_q.lclk_oe_n;
    assign engine_status_n = st_q.sta_n;
    assign status_busy_n = st_q.status_busy_n_n;
    assign ready_n = st_q.rdy_n;
    assign engine_power_ready_n = st_q.engine_power_ready_n_n;
    assign page_sync_n = st_q.page_n;
    assign line_sync_n = st_q.line_n;
    assign sleep_ctrl_n = st_q.sleep_n;
    assign heater_on_n = st_q.heat_n;
    assign step_phase = step_code(st_q.step_idx);
    assign exit_step_phase_a = step_phase[1];
    assign exit_step_phase_b = step_phase[0];
    assign exit_step_phase_a_n = ~step_phase[1];
    assign exit_step_phase_b_n = ~step_phase[0];
    assign exit_current_sel_a = st_q.ctrl.cur_sel[0];
    assign exit_current_sel_b = st_q.ctrl.cur_sel[1];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_prefeed_gate: assert property ($rose(st_q.prefeed_seen) |-> $past(st_q.rdy_n) == 1'b0)
        else $error("pre-feed taken while not ready");
    a_start_gate: assert property ($rose(st_q.print_active) |-> $past(st_q.rdy_n) == 1'b0)
        else $error("start taken while not ready");
    a_clock_with_data: assert property (!link_clock_n_oe_n |-> !status_busy_n)
        else $error("link clock driven outside a status frame");
    a_status_in_busy: assert property (!engine_status_n |-> !status_busy_n && !link_clock_n_oe_n)
        else $error("status bit outside busy frame");
    a_busy_exclusive: assert property ($fell(status_busy_n) |->
        $past(st_q.s2.command_busy_n_n) && !$past(st_q.s2.ctrl_power_ready_n_n))
        else $error("status busy entered against command busy");
    a_page_on_line: assert property (!page_sync_n |-> !line_sync_n && $past(st_q.ctrl.scanner_run))
        else $error("page sync without line sync or scanner");
    a_line_period: assert property ($fell(line_sync_n) && st_q.ctrl.scanner_run
        && st_q.line_period == 16'h0004 ##1 st_q.ctrl.scanner_run[*4] |-> $fell(line_sync_n))
        else $error("line sync period wrong");
    a_ready_idle: assert property (!ready_n |-> !st_q.print_active
        && $past(st_q.ctrl.standby && st_q.ctrl.init_done && !st_q.ctrl.fault))
        else $error("ready low while printing or not powered");
    a_cover_power: assert property (st_q.s2.front_open || st_q.s2.rear_open |=> engine_power_ready_n)
        else $error("power ready low with cover open");
    a_sleep_level: assert property (st_q.ctrl.power_save |=> !sleep_ctrl_n)
        else $error("sleep control high in power saving");
    a_heater_level: assert property (!heater_on_n |-> $past(st_q.ctrl.heater_on))
        else $error("heater on without request");
    a_phase_pairs: assert property (exit_step_phase_a_n == !exit_step_phase_a
        && exit_step_phase_b_n == !exit_step_phase_b)
        else $error("exit phase complements differ");

endmodule : pecp_engine_port

// ===== logic/pecp_pkg.sv
// Package with the constants and carrier types of the print engine controller port.
package pecp_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_HALF_NS = 500;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] LINK_HALF_CNT = 8'(LINK_HALF_CYC - 1);
    localparam logic [2:0] WORD_LAST_BIT = 3'h7;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_STAT_TX = 8'h08;
    localparam logic [7:0] REG_CMD_RX = 8'h0c;
    localparam logic [7:0] REG_LINE_PERIOD = 8'h10;
    localparam logic [7:0] REG_LINES_PAGE = 8'h14;
    localparam logic [7:0] REG_STEP_DIV = 8'h18;

    localparam int ST_PREFEED = 6;
    localparam int ST_START = 7;
    localparam int ST_CMD_VALID = 8;
    localparam int ST_TX_ABORT = 11;

    localparam logic [15:0] LINE_PERIOD_RST = 16'h03e8;
    localparam logic [15:0] LINES_PAGE_RST = 16'h0100;
    localparam logic [15:0] STEP_DIV_RST = 16'h2710;

    // Control register, bit 0 at the bottom.
    typedef struct packed {
        logic print_done;
        logic [1:0] cur_sel;
        logic exit_dir;
        logic exit_run;
        logic fault;
        logic standby;
        logic init_done;
        logic scanner_run;
        logic power_save;
        logic heater_on;
    } pecp_ctrl_t;

    localparam pecp_ctrl_t CTRL_RST = '0;

    typedef struct packed {
        logic tx_abort;
        logic print_active;
        logic tx_busy;
        logic cmd_valid;
        logic start_seen;
        logic prefeed_seen;
        logic cmd_busy;
        logic ctrl_ready;
        logic paper_at_exit;
        logic fan_fault;
        logic front_open;
        logic rear_open;
    } pecp_status_t;

    typedef struct packed {
        logic rear_open;
        logic front_open;
        logic fan_alarm;
        logic exit_n;
        logic prefeed_n;
        logic start_n;
        logic ctrl_power_ready_n_n;
        logic command_busy_n_n;
        logic cmd_n;
        logic lclk_n;
    } pecp_pins_t;

    localparam pecp_pins_t PINS_IDLE = 10'h07f;

    typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_LOW, TX_HIGH, TX_TAIL} pecp_tx_t;

    typedef struct packed {
        pecp_pins_t s1;
        pecp_pins_t s2;
        pecp_pins_t prev;
        pecp_ctrl_t ctrl;
        logic [15:0] line_period;
        logic [15:0] lines_page;
        logic [15:0] step_div;
        logic [31:0] rdata;
        pecp_tx_t tx;
        logic [7:0] tx_word;
        logic [7:0] tx_sh;
        logic [2:0] tx_bit;
        logic [7:0] tx_cnt;
        logic tx_pend;
        logic tx_abort;
        logic [7:0] rx_sh;
        logic [7:0] rx_word;
        logic [2:0] rx_bit;
        logic cmd_valid;
        logic prefeed_seen;
        logic start_seen;
        logic print_active;
        logic [15:0] line_cnt;
        logic [15:0] page_cnt;
        logic [15:0] step_cnt;
        logic [1:0] step_idx;
        logic sta_n;
        logic status_busy_n_n;
        logic lclk_o;
        logic lclk_oe_n;
        logic rdy_n;
        logic engine_power_ready_n_n;
        logic page_n;
        logic line_n;
        logic sleep_n;
        logic heat_n;
    } pecp_state_t;

endpackage : pecp_pkg

// ===== bench/pecp_ctrl_model.sv
// Behavioural model of the controller board on the far side of the engine port.
`timescale 1ns/1ps
module pecp_ctrl_model
    import pecp_pkg::*;
(
    input wire logic link_wire,
    input wire logic engine_status_n,
    input wire logic status_busy_n,
    input wire logic engine_power_ready_n,
    output logic ctrl_power_ready_n,
    output logic command_busy_n,
    output logic command_n,
    output logic link_clock_n,
    output logic link_drive
);
    logic [7:0] rx_stat;
    logic video_a_n;
    logic video_b_n;
    int rx_cnt;
    initial
    begin
        ctrl_power_ready_n = 1'b1;
        command_busy_n = 1'b1;
        command_n = 1'b1;
        link_clock_n = 1'b1;
        link_drive = 1'b0;
        // No image is sent in this bench, so both video lines stay white.
        video_a_n = 1'b1;
        video_b_n = 1'b1;
        rx_cnt = 0;
        #100 ctrl_power_ready_n = 1'b0;
    end
    // Status bits are taken on the rising link edge, first bit the most significant.
    always @(posedge link_wire)
        if (!status_busy_n)
        begin
            rx_stat = {rx_stat[6:0], ~engine_status_n};
            rx_cnt++;
        end
    task automatic send_cmd(input logic [7:0] w);
        wait (status_busy_n && !engine_power_ready_n);
        command_busy_n = 1'b0;
        #200 link_drive = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            link_clock_n = 1'b0;
            command_n = ~w[i];
            #62.5 link_clock_n = 1'b1;
            #62.5;
        end
        link_drive = 1'b0;
        command_n = 1'b1;
        #200 command_busy_n = 1'b1;
    endtask : send_cmd
    // Breaks the exclusion on purpose by claiming the link in mid status frame.
    task automatic break_frame();
        wait (!status_busy_n);
        #3000 command_busy_n = 1'b0;
        #500 command_busy_n = 1'b1;
    endtask : break_frame
endmodule : pecp_ctrl_model

// ===== bench/tb.sv
// Self-checking testbench of the engine port against the controller model.
`timescale 1ns/1ps
module tb;
    import pecp_pkg::*;
    logic ref_clk, nrst, reg_wr, reg_rd, rear, front, fan, exit_n, pf_n, st_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic ctrl_power_ready_n_n, command_busy_n_n, cmd_n, m_clk, m_drv, lclk_o, lclk_oe_n, link_wire, sta_n, status_busy_n_n;
    logic ready_n, engine_power_ready_n_n, page_n, line_n, sleep_n, heat_n, pa, pb, pa_n, pb_n, cs_a, cs_b;
    logic [1:0] cur;
    logic [3:0] pat [5] = '{4'hf, 4'h4, 4'h2, 4'h8, 4'h0};
    logic [1:0] nxt [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
    int error_cnt, total_checks, n;
    pecp_ctrl_t c;
    assign link_wire = !lclk_oe_n ? lclk_o : (m_drv ? m_clk : 1'b1);
    pecp_engine_port pecp_engine_port_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rear_cover_open(rear), .front_cover_open(front), .fan_alarm(fan),
        .exit_sensor_n(exit_n), .prefeed_req_n(pf_n), .start_req_n(st_n),
        .ctrl_power_ready_n(ctrl_power_ready_n_n), .command_busy_n(command_busy_n_n), .command_n(cmd_n),
        .link_clock_n_i(link_wire), .link_clock_n_o(lclk_o), .link_clock_n_oe_n(lclk_oe_n),
        .engine_status_n(sta_n), .status_busy_n(status_busy_n_n), .ready_n(ready_n),
        .engine_power_ready_n(engine_power_ready_n_n), .page_sync_n(page_n), .line_sync_n(line_n),
        .sleep_ctrl_n(sleep_n), .heater_on_n(heat_n), .exit_step_phase_a(pa),
        .exit_step_phase_b(pb), .exit_step_phase_a_n(pa_n), .exit_step_phase_b_n(pb_n),
        .exit_current_sel_a(cs_a), .exit_current_sel_b(cs_b));
    pecp_ctrl_model pecp_ctrl_model_i (.link_wire(link_wire), .engine_status_n(sta_n),
        .status_busy_n(status_busy_n_n), .engine_power_ready_n(engine_power_ready_n_n), .ctrl_power_ready_n(ctrl_power_ready_n_n),
        .command_busy_n(command_busy_n_n), .command_n(cmd_n), .link_clock_n(m_clk), .link_drive(m_drv));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask : rdc
    task automatic ctl();
        wr(REG_CTRL, 32'(c));
        step(3);
    endtask : ctl
    task automatic pulse(input bit st);
        @(posedge ref_clk);
        if (st)
            st_n <= 1'b0;
        else
            pf_n <= 1'b0;
        step(5);
        @(posedge ref_clk);
        st_n <= 1'b1;
        pf_n <= 1'b1;
        step(6);
    endtask : pulse
    task automatic gap(input bit pg, input int exp);
        int g;
        for (int k = 0; k < 2; k++)
        begin
            g = 0;
            if (k)
                step(1);
            while ((pg ? page_n : line_n) !== 1'b0 && g < 200)
            begin
                step(1);
                g++;
            end
        end
        chk(pg ? "page gap" : "line gap", g + 1, exp);
    endtask : gap
    initial
    begin
        #300000;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, rear, front, fan, exit_n} = '0;
        {pf_n, st_n} = 2'h3;
        c = CTRL_RST;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        #1 chk("reset pins", 32'({ready_n, engine_power_ready_n_n, page_n, line_n, sleep_n, heat_n, status_busy_n_n,
            lclk_oe_n, pa, pb, pa_n, pb_n, cs_a, cs_b}), 32'h3fcc);
        rdc("ctrl", REG_CTRL, 32'(CTRL_RST));
        rdc("line period", REG_LINE_PERIOD, 32'(LINE_PERIOD_RST));
        rdc("lines page", REG_LINES_PAGE, 32'(LINES_PAGE_RST));
        rdc("step div", REG_STEP_DIV, 32'(STEP_DIV_RST));
        rdc("unmapped", 8'h1c, 32'h0);
        c.heater_on = 1'b1;
        ctl();
        foreach (pat[i])
        begin
            @(posedge ref_clk);
            {rear, front, fan, exit_n} <= pat[i];
            step(4);
            rdc("pins", REG_STATUS, {27'h0, 1'b1, pat[i][0], pat[i][1], pat[i][2], pat[i][3]});
            chk("heater", 32'(heat_n), 32'(pat[i][3] | pat[i][2]));
        end
        c.power_save = 1'b1;
        ctl();
        chk("sleep", 32'(sleep_n), 32'h0);
        c.power_save = 1'b0;
        c.init_done = 1'b1;
        ctl();
        chk("sleep off", 32'(sleep_n), 32'h1);
        chk("power ready", 32'(engine_power_ready_n_n), 32'h0);
        c.fault = 1'b1;
        ctl();
        chk("power fault", 32'(engine_power_ready_n_n), 32'h1);
        c.fault = 1'b0;
        ctl();
        pulse(1'b1);
        pulse(1'b0);
        rdc("refused", REG_STATUS, 32'h10);
        c.standby = 1'b1;
        ctl();
        chk("ready", 32'(ready_n), 32'h0);
        pulse(1'b0);
        rdc("prefeed", REG_STATUS, 32'h10 | (32'h1 << ST_PREFEED));
        pulse(1'b1);
        chk("busy", 32'(ready_n), 32'h1);
        rdc("start", REG_STATUS, 32'h90 | (32'h1 << ST_PREFEED) | 32'h400);
        wr(REG_CTRL, 32'(c) | 32'h400);
        wr(REG_STATUS, 32'hfc0);
        step(3);
        chk("ready again", 32'(ready_n), 32'h0);
        pecp_ctrl_model_i.send_cmd(8'ha5);
        step(5);
        rdc("command", REG_CMD_RX, 32'ha5);
        rdc("cmd flag", REG_STATUS, 32'h110);
        pecp_ctrl_model_i.rx_cnt = 0;
        wr(REG_STAT_TX, 32'h3c);
        step(3);
        chk("status busy", 32'(status_busy_n_n), 32'h0);
        n = 0;
        while (pecp_ctrl_model_i.rx_cnt < 8 && n < 2000)
        begin
            step(1);
            n++;
        end
        chk("status word", 32'(pecp_ctrl_model_i.rx_stat), 32'h3c);
        step(120);
        chk("released", 32'({status_busy_n_n, lclk_oe_n}), 32'h3);
        fork
            pecp_ctrl_model_i.break_frame();
            wr(REG_STAT_TX, 32'h55);
        join
        step(3);
        chk("abort", 32'({status_busy_n_n, lclk_oe_n}), 32'h3);
        rdc("abort flag", REG_STATUS, 32'h110 | (32'h1 << ST_TX_ABORT));
        wr(REG_LINE_PERIOD, 32'h4);
        wr(REG_LINES_PAGE, 32'h3);
        c.scanner_run = 1'b1;
        ctl();
        gap(1'b0, 4);
        gap(1'b1, 12);
        c.scanner_run = 1'b0;
        ctl();
        n = 0;
        repeat (100)
        begin
            step(1);
            n += int'(line_n !== 1'b1 || page_n !== 1'b1);
        end
        chk("sync off", n, 0);
        wr(REG_STEP_DIV, 32'h3);
        c.exit_run = 1'b1;
        c.cur_sel = 2'h2;
        ctl();
        chk("current sel", 32'({cs_b, cs_a}), 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            cur = {pa, pb};
            n = 0;
            while ({pa, pb} === cur && n < 20)
            begin
                step(1);
                n++;
            end
            chk("phase", 32'({pa, pb}), 32'(nxt[cur]));
            chk("phase comp", 32'({pa_n, pb_n}), 32'({~pa, ~pb}));
            if (i > 0)
                chk("step gap", n, 4);
        end
        finish_test();
    end
endmodule : tb
